// ---- pll_profile_pkg.sv ----
// Purpose: constants and types for the first reference profile bank
// Assumes: axi4-lite slave, one byte register per aligned word
// Notes:   byte address is four times the register index
package pll_profile_pkg;

  localparam int          ADDR_W       = 16;
  localparam int          NUM_REGS     = 13;
  // register indices; byte address is index times four
  localparam logic [13:0] PRIO_IDX     = 14'h0440;
  localparam logic [13:0] BW_LOW_IDX   = 14'h0441;
  localparam logic [13:0] BW_MID_IDX   = 14'h0442;
  localparam logic [13:0] BW_HIGH_IDX  = 14'h0443;
  localparam logic [13:0] DIV_LOW_IDX  = 14'h0444;
  localparam logic [13:0] DIV_MID_IDX  = 14'h0445;
  localparam logic [13:0] DIV_HIGH_IDX = 14'h0446;
  localparam logic [13:0] NUM_LOW_IDX  = 14'h0447;
  localparam logic [13:0] NUM_MID_IDX  = 14'h0448;
  localparam logic [13:0] NUM_HIGH_IDX = 14'h0449;
  localparam logic [13:0] MOD_LOW_IDX  = 14'h044a;
  localparam logic [13:0] MOD_MID_IDX  = 14'h044b;
  localparam logic [13:0] MOD_HIGH_IDX = 14'h044c;
  // field positions
  localparam int          ENABLE_BIT   = 0;
  localparam int          PRIO_LSB     = 1;
  localparam int          BW16_BIT     = 0;
  localparam int          FILTER_BIT   = 1;
  // reset value and writable bits per slot
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  REG_MASK [NUM_REGS] = '{
    8'h07, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } chan_state_t;

  typedef struct packed {
    logic        ref_enable;
    logic [1:0]  ref_priority;
    logic [16:0] loop_bw_scale;
    logic        high_margin;
    logic [17:0] int_div_m1;
    logic [18:0] fb_int_ratio;
    logic [23:0] frac_num;
    logic [23:0] frac_mod;
    logic        frac_enable;
  } profile_t;

endpackage : pll_profile_pkg

// ---- pll_ref_profile_regs.sv ----
// Purpose: register bank for the pll channel zero first reference profile
// Assumes: axi4-lite master, one write and one read outstanding at most
// Notes:   profile outputs are registered one cycle behind the bank
// Operation
// - priority field bits 2:1, 00 highest, up to level 3.
// - bit 0 enables locking to the first reference; 0 forbids it.
// - 17-bit bandwidth scale, 0.1 Hz units, bit 16 in third byte.
// - third byte bit 1 selects normal or high phase margin filter.
// - 18-bit integer divider stored minus one; zero divides by one.
// - 24-bit numerator, three bytes, least significant byte first.
// - 24-bit modulus, three bytes, least significant byte first.
// - zero modulus disables and bypasses the fractional divider.
// - all fields reset to zero.
`timescale 1ns/10ps
module pll_ref_profile_regs (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  // axi4-lite write address
  input  wire logic [15:0]           awaddr_in,
  input  wire logic                  awvalid_in,
  output logic                       awready_out,
  // axi4-lite write data
  input  wire logic [31:0]           wdata_in,
  input  wire logic [3:0]            wstrb_in,
  input  wire logic                  wvalid_in,
  output logic                       wready_out,
  // axi4-lite write response
  output logic [1:0]                 bresp_out,
  output logic                       bvalid_out,
  input  wire logic                  bready_in,
  // axi4-lite read address
  input  wire logic [15:0]           araddr_in,
  input  wire logic                  arvalid_in,
  output logic                       arready_out,
  // axi4-lite read data
  output logic [31:0]                rdata_out,
  output logic [1:0]                 rresp_out,
  output logic                       rvalid_out,
  input  wire logic                  rready_in,
  // profile to the pll core
  output pll_profile_pkg::profile_t  profile_out
);

  // address to slot decode, used by both channels
  function automatic logic [4:0] slot_of(input logic [15:0] addr);
    logic [13:0] idx;
    logic [13:0] off;
    idx = addr[15:2];
    off = idx - pll_profile_pkg::PRIO_IDX;
    if (addr[1:0] != 2'h0) begin
      slot_of = 5'h10;
    end else if (idx < pll_profile_pkg::PRIO_IDX) begin
      slot_of = 5'h10;
    end else if (idx > pll_profile_pkg::MOD_HIGH_IDX) begin
      slot_of = 5'h10;
    end else begin
      slot_of = {1'b0, off[3:0]};
    end
  endfunction : slot_of

  logic [7:0]  bank_r [pll_profile_pkg::NUM_REGS];
  logic        aw_held_r;
  logic [15:0] awaddr_r;
  logic        w_held_r;
  logic [7:0]  wbyte_r;
  logic        wlane0_r;
  pll_profile_pkg::chan_state_t wr_state_r;
  pll_profile_pkg::chan_state_t rd_state_r;
  logic [1:0]  bresp_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  pll_profile_pkg::profile_t profile_r;
  pll_profile_pkg::profile_t profile_nxt;

  wire         wr_fire  = aw_held_r && w_held_r &&
                          (wr_state_r == pll_profile_pkg::CH_IDLE);
  wire  [4:0]  wr_slot  = slot_of(awaddr_r);
  wire         wr_hit   = !wr_slot[4];
  wire         ar_fire  = arvalid_in && arready_out;
  wire  [4:0]  rd_slot  = slot_of(araddr_in);
  wire         rd_hit   = !rd_slot[4];
  wire  [23:0] mod_word = {bank_r[12], bank_r[11], bank_r[10]};
  wire  [17:0] div_m1   = {bank_r[6][1:0], bank_r[5], bank_r[4]};

  assign awready_out = !aw_held_r;
  assign wready_out  = !w_held_r;
  assign bvalid_out  = (wr_state_r == pll_profile_pkg::CH_RESP);
  assign bresp_out   = bresp_r;
  assign arready_out = (rd_state_r == pll_profile_pkg::CH_IDLE);
  assign rvalid_out  = (rd_state_r == pll_profile_pkg::CH_RESP);
  assign rdata_out   = rdata_r;
  assign rresp_out   = rresp_r;
  assign profile_out = profile_r;

  // write address and data are caught in either order
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 16'h0000;
      w_held_r  <= 1'b0;
      wbyte_r   <= 8'h00;
      wlane0_r  <= 1'b0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= awaddr_in;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_held_r <= 1'b1;
        wbyte_r  <= wdata_in[7:0];
        wlane0_r <= wstrb_in[0];
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response channel
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_state_r <= pll_profile_pkg::CH_IDLE;
      bresp_r    <= pll_profile_pkg::RESP_OKAY;
    end else begin
      case (wr_state_r)
        pll_profile_pkg::CH_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= pll_profile_pkg::CH_RESP;
            bresp_r    <= wr_hit ? pll_profile_pkg::RESP_OKAY
                                 : pll_profile_pkg::RESP_SLVERR;
          end
        end
        pll_profile_pkg::CH_RESP: begin
          if (bready_in) begin
            wr_state_r <= pll_profile_pkg::CH_IDLE;
          end
        end
        default: begin
          wr_state_r <= pll_profile_pkg::CH_IDLE;
        end
      endcase
    end
  end

  // one byte register per slot, reserved bits masked off
  for (genvar i = 0; i < pll_profile_pkg::NUM_REGS; i++) begin : g_bank
    wire wr_this = wr_fire && wr_hit && wlane0_r &&
                   (wr_slot[3:0] == 4'(i));
    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        bank_r[i] <= pll_profile_pkg::REG_RESET;
      end else if (wr_this) begin
        bank_r[i] <= wbyte_r & pll_profile_pkg::REG_MASK[i];
      end
    end
  end

  // read channel, unmapped reads answer slverr with zero data
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_state_r <= pll_profile_pkg::CH_IDLE;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= pll_profile_pkg::RESP_OKAY;
    end else begin
      case (rd_state_r)
        pll_profile_pkg::CH_IDLE: begin
          if (ar_fire) begin
            rd_state_r <= pll_profile_pkg::CH_RESP;
            rdata_r    <= rd_hit ? {24'h00_0000, bank_r[rd_slot[3:0]]}
                                 : 32'h0000_0000;
            rresp_r    <= rd_hit ? pll_profile_pkg::RESP_OKAY
                                 : pll_profile_pkg::RESP_SLVERR;
          end
        end
        pll_profile_pkg::CH_RESP: begin
          if (rready_in) begin
            rd_state_r <= pll_profile_pkg::CH_IDLE;
          end
        end
        default: begin
          rd_state_r <= pll_profile_pkg::CH_IDLE;
        end
      endcase
    end
  end

  // profile fields assembled from the bank
  always_comb begin
    profile_nxt = '0;
    profile_nxt.ref_enable    =
      bank_r[0][pll_profile_pkg::ENABLE_BIT];
    profile_nxt.ref_priority  =
      bank_r[0][pll_profile_pkg::PRIO_LSB +: 2];
    profile_nxt.loop_bw_scale = {bank_r[3][pll_profile_pkg::BW16_BIT],
                                 bank_r[2], bank_r[1]};
    profile_nxt.high_margin   =
      bank_r[3][pll_profile_pkg::FILTER_BIT];
    profile_nxt.int_div_m1    = div_m1;
    profile_nxt.fb_int_ratio  = {1'b0, div_m1} + 19'h00001;
    profile_nxt.frac_num      = {bank_r[9], bank_r[8], bank_r[7]};
    profile_nxt.frac_mod      = mod_word;
    profile_nxt.frac_enable   = (mod_word != 24'h00_0000);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      profile_r <= '0;
    end else begin
      profile_r <= profile_nxt;
    end
  end

  // checks
  sequence wr_numhi_s;
    wr_fire && wlane0_r && (awaddr_r[1:0] == 2'h0) &&
    (awaddr_r[15:2] == pll_profile_pkg::NUM_HIGH_IDX);
  endsequence

  sequence rd_prio_s;
    ar_fire && (araddr_in[15:2] == pll_profile_pkg::PRIO_IDX) &&
    (araddr_in[1:0] == 2'h0);
  endsequence

  reset_zero_a: assert property (@(posedge core_clk_in)
    $past(rst_in) |-> (profile_r == '0) && (bank_r[3] == 8'h00))
    else $error("profile not zero after reset");

  prio_field_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |-> profile_r.ref_priority == $past(bank_r[0][2:1]))
    else $error("priority field mismatch");

  enable_gate_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |-> profile_r.ref_enable == $past(bank_r[0][0]))
    else $error("enable bit mismatch");

  bw_scale_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |-> profile_r.loop_bw_scale ==
      $past({bank_r[3][0], bank_r[2], bank_r[1]}))
    else $error("bandwidth scale mismatch");

  filter_sel_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |-> profile_r.high_margin == $past(bank_r[3][1]))
    else $error("filter select mismatch");

  int_ratio_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) && (profile_r.int_div_m1 == 18'h0_0000) |->
      profile_r.fb_int_ratio == 19'h0_0001)
    else $error("zero divider is not divide by one");

  ratio_plus_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |->
      profile_r.fb_int_ratio == {1'b0, profile_r.int_div_m1} + 19'h00001)
    else $error("ratio is not divider plus one");

  numer_order_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    wr_numhi_s |=> ##1 profile_r.frac_num[23:16] == $past(wbyte_r, 2))
    else $error("numerator high byte misplaced");

  frac_bypass_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    profile_r.frac_enable == (profile_r.frac_mod != 24'h00_0000))
    else $error("fractional bypass wrong");

  reserved_zero_a: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    rd_prio_s |=> rvalid_out && (rdata_out[31:3] == 29'h0))
    else $error("reserved bits read nonzero");

endmodule : pll_ref_profile_regs

// ---- pll_ref_profile_regs_tb.sv ----
// Purpose: self-checking bench for the first reference profile bank
// Assumes: axi4-lite access, one byte per word, byte address index*4
// Notes:   profile output checked one edge after each group of writes returns
`timescale 1ns/10ps
module pll_ref_profile_regs_tb;
  logic                      core_clk_in;
  logic                      rst_in;
  logic [15:0]               awaddr_in;
  logic                      awvalid_in;
  logic                      awready_out;
  logic [31:0]               wdata_in;
  logic [3:0]                wstrb_in;
  logic                      wvalid_in;
  logic                      wready_out;
  logic [1:0]                bresp_out;
  logic                      bvalid_out;
  logic                      bready_in;
  logic [15:0]               araddr_in;
  logic                      arvalid_in;
  logic                      arready_out;
  logic [31:0]               rdata_out;
  logic [1:0]                rresp_out;
  logic                      rvalid_out;
  logic                      rready_in;
  pll_profile_pkg::profile_t profile_out;
  pll_profile_pkg::profile_t e;
  int                        errors;
  int                        compares;
  logic [7:0]                mask [13] = '{8'h07, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  pll_ref_profile_regs pll_ref_profile_regs_inst (
    .core_clk_in (core_clk_in), .rst_in     (rst_in),
    .awaddr_in   (awaddr_in),   .awvalid_in (awvalid_in),
    .awready_out (awready_out), .wdata_in   (wdata_in),
    .wstrb_in    (wstrb_in),    .wvalid_in  (wvalid_in),
    .wready_out  (wready_out),  .bresp_out  (bresp_out),
    .bvalid_out  (bvalid_out),  .bready_in  (bready_in),
    .araddr_in   (araddr_in),   .arvalid_in (arvalid_in),
    .arready_out (arready_out), .rdata_out  (rdata_out),
    .rresp_out   (rresp_out),   .rvalid_out (rvalid_out),
    .rready_in   (rready_in),   .profile_out (profile_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic finish_test;
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang(input int n);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
  endtask : hang

  task automatic wr(input logic [13:0] idx, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int   n;
    logic ad;
    logic wd;
    logic got;
    n = 0; ad = 1'b0; wd = 1'b0; got = 1'b0;
    awaddr_in  <= {idx, 2'b00};
    wdata_in   <= {24'h0, d};
    wstrb_in   <= s;
    awvalid_in <= 1'b1;
    wvalid_in  <= 1'b1;
    bready_in  <= 1'b1;
    while (!(ad && wd) && n < 50) begin
      @(posedge core_clk_in);
      n++;
      if (!ad && awready_out === 1'b1) begin
        ad = 1'b1;
        awvalid_in <= 1'b0;
      end
      if (!wd && wready_out === 1'b1) begin
        wd = 1'b1;
        wvalid_in <= 1'b0;
      end
    end
    while (!got && n < 50) begin
      @(posedge core_clk_in);
      n++;
      if (bvalid_out === 1'b1) begin
        got = 1'b1;
        bready_in <= 1'b0;
        chk(32'(bresp_out), 32'(er));
      end
    end
    @(posedge core_clk_in);
    hang(n);
  endtask : wr

  task automatic rd(input logic [13:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int   n;
    logic ad;
    logic got;
    n = 0; ad = 1'b0; got = 1'b0;
    araddr_in  <= {idx, 2'b00};
    arvalid_in <= 1'b1;
    rready_in  <= 1'b1;
    while (!got && n < 50) begin
      @(posedge core_clk_in);
      n++;
      if (!ad && arready_out === 1'b1) begin
        ad = 1'b1;
        arvalid_in <= 1'b0;
      end else if (ad && rvalid_out === 1'b1) begin
        got = 1'b1;
        rready_in <= 1'b0;
        chk(rdata_out, {24'h0, d});
        chk(32'(rresp_out), 32'(er));
      end
    end
    @(posedge core_clk_in);
    hang(n);
  endtask : rd

  task automatic pchk;
    @(posedge core_clk_in);
    #1;
    chk(32'(profile_out.ref_enable), 32'(e.ref_enable));
    chk(32'(profile_out.ref_priority), 32'(e.ref_priority));
    chk(32'(profile_out.loop_bw_scale), 32'(e.loop_bw_scale));
    chk(32'(profile_out.high_margin), 32'(e.high_margin));
    chk(32'(profile_out.int_div_m1), 32'(e.int_div_m1));
    chk(32'(profile_out.fb_int_ratio), 32'(e.fb_int_ratio));
    chk(32'(profile_out.frac_num), 32'(e.frac_num));
    chk(32'(profile_out.frac_mod), 32'(e.frac_mod));
    chk(32'(profile_out.frac_enable), 32'(e.frac_enable));
  endtask : pchk

  initial begin
    errors = 0; compares = 0;
    rst_in = 1'b1; awaddr_in = 16'h0; awvalid_in = 1'b0;
    wdata_in = 32'h0; wstrb_in = 4'h0; wvalid_in = 1'b0;
    bready_in = 1'b0; araddr_in = 16'h0; arvalid_in = 1'b0;
    rready_in = 1'b0;
    e = '0;
    e.fb_int_ratio = 19'h00001;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 13; i++)
      rd(pll_profile_pkg::PRIO_IDX + 14'(i), 8'h00, 2'h0);
    pchk();
    for (int i = 0; i < 13; i++)
      wr(pll_profile_pkg::PRIO_IDX + 14'(i), 8'hff, 4'h1, 2'h0);
    for (int i = 0; i < 13; i++)
      rd(pll_profile_pkg::PRIO_IDX + 14'(i), mask[i], 2'h0);
    e = '{1'b1, 2'h3, 17'h1ffff, 1'b1, 18'h3ffff, 19'h40000,
          24'hffffff, 24'hffffff, 1'b1};
    pchk();
    e.ref_enable = 1'b0;
    for (int p = 0; p < 4; p++) begin
      wr(pll_profile_pkg::PRIO_IDX, {5'h1f, 2'(p), 1'b0}, 4'h1, 2'h0);
      e.ref_priority = 2'(p);
      pchk();
    end
    wr(pll_profile_pkg::BW_LOW_IDX, 8'h34, 4'h1, 2'h0);
    wr(pll_profile_pkg::BW_MID_IDX, 8'h12, 4'h1, 2'h0);
    wr(pll_profile_pkg::BW_HIGH_IDX, 8'hfe, 4'h1, 2'h0);
    wr(pll_profile_pkg::DIV_LOW_IDX, 8'h01, 4'h1, 2'h0);
    wr(pll_profile_pkg::DIV_MID_IDX, 8'h02, 4'h1, 2'h0);
    wr(pll_profile_pkg::DIV_HIGH_IDX, 8'h01, 4'h1, 2'h0);
    for (int i = 0; i < 6; i++)
      wr(pll_profile_pkg::NUM_LOW_IDX + 14'(i), 8'(8'h11 * (i + 1)),
         4'h1, 2'h0);
    e.loop_bw_scale = 17'h01234;
    e.high_margin   = 1'b1;
    e.int_div_m1    = 18'h10201;
    e.fb_int_ratio  = 19'h10202;
    e.frac_num      = 24'h332211;
    e.frac_mod      = 24'h665544;
    pchk();
    wr(pll_profile_pkg::NUM_LOW_IDX, 8'haa, 4'h0, 2'h0);
    rd(pll_profile_pkg::NUM_LOW_IDX, 8'h11, 2'h0);
    for (int i = 0; i < 3; i++)
      wr(pll_profile_pkg::MOD_LOW_IDX + 14'(i), 8'h00, 4'h1, 2'h0);
    e.frac_mod    = 24'h000000;
    e.frac_enable = 1'b0;
    pchk();
    wr(14'h044d, 8'h5a, 4'h1, 2'h2);
    rd(14'h044d, 8'h00, 2'h2);
    pchk();
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    e = '0;
    e.fb_int_ratio = 19'h00001;
    for (int i = 0; i < 13; i++)
      rd(pll_profile_pkg::PRIO_IDX + 14'(i), 8'h00, 2'h0);
    pchk();
    finish_test();
  end
endmodule : pll_ref_profile_regs_tb
